// ---- alp_amp_device.sv ----
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Limiter acts only in amplifier mode
// - Limiter input is signed full-scale fraction
// - Output is input times gain times 5.91, supply-clamped
// - Gain attenuates 248 steps of 0.5 dB
// - Code 00h is 0 dB, default
// - Fourth-order modulator drives 3-level bridge outputs
// - Clip select 0 smooth, 1 maximum power
// - PWM rate 256/352.8/384 kHz by family
// - Over-temperature floats both output stages
// - Over-temperature clears by host or timer
// - No-recovery temperature fault cleared by off-amp cycle
// - Over-current floats the output stages
// - Over-current clears by host or timer
// - No-recovery current fault cleared by off-amp cycle
// - Too-slow input clock floats outputs
// - Under-frequency flag in status
// - Too-fast input clock floats outputs
// - Over-frequency flag in status
// - Bad bit-clock ratio cuts audio path
// - PCM ratios 16,32,48,64,96,128,192 only
// - I2S ratios 32 or 64 only
// - Under-frequency below 96 kHz, auto restart
// - Over-frequency above 1031 kHz, auto restart
module alp_amp_device
  import alp_pkg::*;
#(
  parameter int OTP_MID_CYC = OTP_MID_CYC_DEF,
  parameter int OTP_LONG_CYC = OTP_LONG_CYC_DEF,
  parameter int OCP_MID_CYC = OCP_MID_CYC_DEF,
  parameter int OCP_LONG_CYC = OCP_LONG_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  alp_link_if.dev link,
  input wire logic over_temp_alarm,
  input wire logic over_current_alarm,
  input wire logic [SUPPLY_W-1:0] power_stage_supply,
  output logic speaker_out_pos,
  output logic speaker_out_pos_oe,
  output logic speaker_out_neg,
  output logic speaker_out_neg_oe,
  output logic signed [MV_W-1:0] drive_level_mv
);
  logic [1:0] sck_sy, ws_sy, sd_sy, ot_sy, oc_sy;
  logic [SUPPLY_W-1:0] sup_sy0, sup_sy1;
  logic sck_d, ws_last, frame_seen;
  logic [4:0] bit_idx;
  logic [AUDIO_W-1:0] shift;
  logic signed [AUDIO_W-1:0] sample_in, y_r;
  logic [BCR_W-1:0] sck_cnt;
  logic [PER_W-1:0] per_cnt;
  logic low_freq_fault, high_freq_fault, bad_bitclock_ratio_fault;
  logic [1:0] hw_flag;
  logic [REC_W-1:0] rec_timer [2];
  logic amp_prev;
  logic [DIV_W-1:0] div_cnt;
  logic signed [INT_W-1:0] i1, i2, i3, i4;
  // Pin inputs pass two flops before any logic
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_sy <= '0;
      ws_sy <= '0;
      sd_sy <= '0;
      ot_sy <= '0;
      oc_sy <= '0;
      sup_sy0 <= '0;
      sup_sy1 <= '0;
      sck_d <= 1'b0;
    end
    else
    begin
      sck_sy <= {sck_sy[0], link.sck};
      ws_sy <= {ws_sy[0], link.ws};
      sd_sy <= {sd_sy[0], link.sd};
      ot_sy <= {ot_sy[0], over_temp_alarm};
      oc_sy <= {oc_sy[0], over_current_alarm};
      sup_sy0 <= power_stage_supply;
      sup_sy1 <= sup_sy0;
      sck_d <= sck_sy[1];
    end
  end
  wire sck_rise = sck_sy[1] & ~sck_d;
  wire ws_rise = sck_rise & ws_sy[1] & ~ws_last;
  wire ws_fall = sck_rise & ~ws_sy[1] & ws_last;
  wire ch_start = link.pcm_format ? ws_rise : ws_fall;
  // I2S data lags its word-select edge by one bit clock
  wire [4:0] data_ofs = link.pcm_format ? 5'h00 : 5'h01;
  wire [4:0] bit_pos = ch_start ? 5'h00 : bit_idx;
  wire in_word = (bit_pos >= data_ofs) && (bit_pos < data_ofs + 5'(AUDIO_W));
  wire word_last = bit_pos == data_ofs + 5'(AUDIO_W - 1);
  wire [1:0] oct = link.sample_rate_select[SRS_OCT_LSB +: 2];
  wire [PER_W-1:0] ufp_lim = UFP_PER_MAX >> oct;
  wire [PER_W-1:0] ofp_lim = OFP_PER_MIN >> oct;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Word select idles high, so reset must not fake a frame edge
      ws_last <= 1'b1;
      bit_idx <= '1;
      shift <= '0;
      sample_in <= '0;
    end
    else if (sck_rise)
    begin
      ws_last <= ws_sy[1];
      bit_idx <= (bit_pos == '1) ? bit_pos : bit_pos + 5'h01;
      if (in_word)
        shift <= {shift[AUDIO_W-2:0], sd_sy[1]};
      if (in_word && word_last)
        sample_in <= {shift[AUDIO_W-2:0], sd_sy[1]};
    end
  end
  // Frame checks: bit clocks per frame and frame period in system clocks
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_cnt <= '0;
      per_cnt <= '0;
      frame_seen <= 1'b0;
      low_freq_fault <= 1'b0;
      high_freq_fault <= 1'b0;
      bad_bitclock_ratio_fault <= 1'b0;
    end
    else
    begin
      per_cnt <= (ws_rise) ? PER_W'(1) : ((per_cnt == '1) ? per_cnt : per_cnt + PER_W'(1));
      if (ws_rise)
      begin
        sck_cnt <= BCR_W'(1);
        frame_seen <= 1'b1;
        if (frame_seen)
        begin
          bad_bitclock_ratio_fault <= ~bitclk_ratio_ok(link.pcm_format, sck_cnt);
          low_freq_fault <= per_cnt > ufp_lim;
          high_freq_fault <= per_cnt < ofp_lim;
        end
      end
      else
      begin
        if (sck_rise && sck_cnt != '1)
          sck_cnt <= sck_cnt + BCR_W'(1);
        // Stalled frame clock trips before the next edge arrives
        if (per_cnt > ufp_lim)
          {low_freq_fault, high_freq_fault} <= 2'b10;
      end
    end
  end
  // Temperature and current faults: index 0 temperature, 1 current
  wire [1:0] hw_cond = {oc_sy[1], ot_sy[1]};
  wire amp_restart = link.amp_mode & ~amp_prev;
  alp_recovery_t rec_sel [2];
  assign rec_sel[0] = link.otp_recovery;
  assign rec_sel[1] = link.ocp_recovery;
  function automatic logic [REC_W-1:0] rec_limit(input int k, input alp_recovery_t sel);
    if (sel == REC_SHORT)
      return REC_W'(REC_SHORT_CYC);
    if (sel == REC_MID)
      return REC_W'((k == 0) ? OTP_MID_CYC : OCP_MID_CYC);
    return REC_W'((k == 0) ? OTP_LONG_CYC : OCP_LONG_CYC);
  endfunction
  for (genvar k = 0; k < 2; k++)
  begin : g_hard_fault
    wire released = ~hw_cond[k];
    wire timed = rec_sel[k] != REC_NONE;
    wire t_done = timed && rec_timer[k] >= rec_limit(k, rec_sel[k]) - REC_W'(1);
    wire clear = released & (link.fault_clear[k] | t_done | (~timed & amp_restart));
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        hw_flag[k] <= 1'b0;
        rec_timer[k] <= '0;
      end
      else
      begin
        hw_flag[k] <= hw_cond[k] | (hw_flag[k] & ~clear);
        rec_timer[k] <= (hw_flag[k] && released && timed && !t_done) ? rec_timer[k] + REC_W'(1) : '0;
      end
    end
  end
  wire any_fault = |hw_flag | low_freq_fault | high_freq_fault | bad_bitclock_ratio_fault;
  wire drive_en = link.amp_mode & ~any_fault;
  wire path_ok = link.amp_mode & ~bad_bitclock_ratio_fault;
  // Limiter: split code into whole halvings and a fine fraction
  wire signed [AUDIO_W-1:0] x_in = path_ok ? sample_in : '0;
  wire [GAIN_W-1:0] code_c = (link.limiter_gain_code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : link.limiter_gain_code;
  wire [GAIN_W-1:0] coarse = code_c / GAIN_STEPS_PER_6DB;
  wire [GAIN_W-1:0] fine = code_c % GAIN_STEPS_PER_6DB;
  wire signed [AUDIO_W+GAIN_FRAC_W:0] prod = x_in * $signed({1'b0, gain_frac(fine[3:0])});
  wire signed [AUDIO_W+GAIN_FRAC_W:0] scaled = prod >>> (FRAC_SHIFT + int'(coarse));
  wire signed [AUDIO_W+14:0] vprod = y_r * $signed(15'(FS_OUT_MV));
  wire signed [MV_W-1:0] v_mv = vprod[FRAC_SHIFT +: MV_W];
  // Smooth clipping trades peak swing for modulator headroom
  wire [SUPPLY_W-1:0] ceil_u = link.clip_mode_select ? sup_sy1 : sup_sy1 - (sup_sy1 >> CLIP_HEAD_SHIFT);
  wire signed [MV_W-1:0] ceil_mv = $signed({3'b000, ceil_u});
  wire signed [MV_W-1:0] sat_mv = (v_mv > ceil_mv) ? ceil_mv : ((v_mv < -ceil_mv) ? -ceil_mv : v_mv);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      y_r <= '0;
      drive_level_mv <= '0;
      amp_prev <= 1'b0;
    end
    else
    begin
      y_r <= scaled[AUDIO_W-1:0];
      drive_level_mv <= link.amp_mode ? sat_mv : '0;
      amp_prev <= link.amp_mode;
    end
  end
  // Modulator runs at the PWM rate of the selected family
  wire [DIV_W-1:0] div_top = pwm_div(link.sample_rate_select[SRS_FAM_LSB +: 2]) - DIV_W'(1);
  wire pwm_tick = div_cnt >= div_top;
  wire signed [INT_W-1:0] sup = $signed(INT_W'(sup_sy1));
  wire signed [INT_W-1:0] u = INT_W'(drive_level_mv);
  wire signed [INT_W-1:0] fb = speaker_out_pos ? sup : (speaker_out_neg ? -sup : '0);
  wire signed [INT_W+1:0] sum_ff = i1 + i2 + i3 + i4;
  wire signed [INT_W+1:0] thr = $signed((INT_W+2)'(sup_sy1 >> 1));
  function automatic logic signed [INT_W-1:0] sat_int(input logic signed [INT_W+1:0] s);
    if (s > $signed((INT_W+2)'({1'b0, {(INT_W-1){1'b1}}})))
      return {1'b0, {(INT_W-1){1'b1}}};
    if (s < -$signed((INT_W+2)'({1'b0, {(INT_W-1){1'b1}}})))
      return {1'b1, {(INT_W-2){1'b0}}, 1'b1};
    return s[INT_W-1:0];
  endfunction
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= '0;
      {i1, i2, i3, i4} <= '0;
      speaker_out_pos <= 1'b0;
      speaker_out_neg <= 1'b0;
      speaker_out_pos_oe <= 1'b0;
      speaker_out_neg_oe <= 1'b0;
      link.status_flags <= '0;
    end
    else
    begin
      div_cnt <= pwm_tick ? '0 : div_cnt + DIV_W'(1);
      speaker_out_pos_oe <= drive_en;
      speaker_out_neg_oe <= drive_en;
      if (!drive_en)
      begin
        {i1, i2, i3, i4} <= '0;
        speaker_out_pos <= 1'b0;
        speaker_out_neg <= 1'b0;
      end
      else if (pwm_tick)
      begin
        i1 <= sat_int(i1 + u - fb);
        i2 <= sat_int(i2 + (i1 >>> MOD_SHIFT));
        i3 <= sat_int(i3 + (i2 >>> MOD_SHIFT));
        i4 <= sat_int(i4 + (i3 >>> MOD_SHIFT));
        speaker_out_pos <= sum_ff > thr;
        speaker_out_neg <= sum_ff < -thr;
      end
      link.status_flags <= {drive_en, bad_bitclock_ratio_fault, high_freq_fault, low_freq_fault,
                            hw_flag[1], hw_flag[0]};
    end
  end
endmodule // alp_amp_device

// ---- alp_audio_host.sv ----
`timescale 1ns/10ps
module alp_audio_host
  import alp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  alp_link_if.host link
);
  logic ack;
  logic [CTL_W-1:0] ctrl;
  logic [GAIN_W-1:0] gain;
  logic [AUDIO_W-1:0] sample;
  logic [7:0] frame_bits, sck_half, half_cnt, bit_n;
  logic sck_r;

  // Every access waits exactly one cycle, giving registered read data
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  wire wr_go = avs_write & ack;
  wire rd_take = avs_read & ~ack;

  wire [31:0] rd_mux =
    (avs_address == REG_CTRL) ? 32'(ctrl) :
    (avs_address == REG_GAIN) ? 32'(gain) :
    (avs_address == REG_SAMPLE) ? 32'(sample) :
    (avs_address == REG_FRAME) ? {8'h00, sck_half, 8'h00, frame_bits} :
    (avs_address == REG_STATUS) ? 32'(link.status_flags) : 32'h0000_0000;

  assign link.amp_mode = ctrl[CTL_AMP];
  assign link.clip_mode_select = ctrl[CTL_CLIP];
  assign link.pcm_format = ctrl[CTL_PCM];
  assign link.sample_rate_select = ctrl[CTL_SRS_LSB +: SRS_W];
  assign link.otp_recovery = alp_recovery_t'(ctrl[CTL_OTP_LSB +: 2]);
  assign link.ocp_recovery = alp_recovery_t'(ctrl[CTL_OCP_LSB +: 2]);
  assign link.limiter_gain_code = gain;
  assign link.sck = sck_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      avs_readdata <= '0;
      ctrl <= CTRL_RST;
      gain <= GAIN_CODE_RST;
      sample <= '0;
      frame_bits <= FRAME_BITS_RST;
      sck_half <= SCK_HALF_RST;
      link.fault_clear <= '0;
    end
    else
    begin
      ack <= req & ~ack;
      if (rd_take)
        avs_readdata <= rd_mux;
      link.fault_clear <= (wr_go && avs_address == REG_CLEAR) ? avs_writedata[1:0] : 2'b00;
      if (wr_go)
      begin
        if (avs_address == REG_CTRL)
          ctrl <= avs_writedata[CTL_W-1:0];
        if (avs_address == REG_GAIN)
          gain <= avs_writedata[GAIN_W-1:0];
        if (avs_address == REG_SAMPLE)
          sample <= avs_writedata[AUDIO_W-1:0];
        if (avs_address == REG_FRAME)
        begin
          frame_bits <= avs_writedata[FRM_BITS_LSB +: 8];
          sck_half <= avs_writedata[FRM_HALF_LSB +: 8];
        end
      end
    end
  end

  // Bit clock by divider; data and word select change on the falling edge
  wire half_done = half_cnt >= sck_half - 8'h01;
  wire [7:0] next_bit = (bit_n >= frame_bits - 8'h01) ? 8'h00 : bit_n + 8'h01;
  wire [7:0] ofs = link.pcm_format ? 8'h00 : 8'h01;
  wire [7:0] pos = next_bit - ofs;
  wire sd_next = (next_bit >= ofs) && (pos < 8'(AUDIO_W)) && sample[4'(AUDIO_W - 1) - pos[3:0]];
  wire ws_next = link.pcm_format ? (next_bit == 8'h00) : (next_bit >= (frame_bits >> 1));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt <= '0;
      sck_r <= 1'b0;
      bit_n <= FRAME_BITS_RST - 8'h01;
      link.ws <= 1'b1;
      link.sd <= 1'b0;
    end
    else
    begin
      half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
      if (half_done)
      begin
        sck_r <= ~sck_r;
        if (sck_r)
        begin
          bit_n <= next_bit;
          link.ws <= ws_next;
          link.sd <= sd_next;
        end
      end
    end
  end
endmodule // alp_audio_host

// ---- alp_link_if.sv ----
`timescale 1ns/10ps
interface alp_link_if
  import alp_pkg::*;
();
  logic sck;
  logic ws;
  logic sd;
  logic amp_mode;
  logic clip_mode_select;
  logic pcm_format;
  logic [SRS_W-1:0] sample_rate_select;
  logic [GAIN_W-1:0] limiter_gain_code;
  alp_recovery_t otp_recovery;
  alp_recovery_t ocp_recovery;
  logic [1:0] fault_clear;
  logic [ST_W-1:0] status_flags;

  modport dev (
    input sck, ws, sd, amp_mode, clip_mode_select, pcm_format, sample_rate_select,
    input limiter_gain_code, otp_recovery, ocp_recovery, fault_clear,
    output status_flags
  );
  modport host (
    output sck, ws, sd, amp_mode, clip_mode_select, pcm_format, sample_rate_select,
    output limiter_gain_code, otp_recovery, ocp_recovery, fault_clear,
    input status_flags
  );
endinterface

// ---- alp_link_properties.sv ----
`timescale 1ns/10ps
module alp_link_properties
  import alp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic ws,
  input wire logic sd,
  input wire logic amp_mode,
  input wire alp_recovery_t otp_recovery,
  input wire alp_recovery_t ocp_recovery,
  input wire logic [1:0] fault_clear,
  input wire logic [ST_W-1:0] status_flags
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Flags and the drive bit are registered in the same cycle; a fault must still have stood two
  sequence otp_held;
    status_flags[ST_OTP] [*2];
  endsequence
  sequence ocp_held;
    status_flags[ST_OCP] [*2];
  endsequence
  sequence freq_held;
    (status_flags[ST_UFP] || status_flags[ST_OFP]) [*2];
  endsequence
  sequence ratio_held;
    status_flags[ST_IBP] [*2];
  endsequence
  sequence amp_steady;
    amp_mode && $past(amp_mode) && $past(amp_mode, 2);
  endsequence

  otp_float_a: assert property (otp_held |-> !status_flags[ST_DRIVE])
    else $error("drive active during temperature fault");
  ocp_float_a: assert property (ocp_held |-> !status_flags[ST_DRIVE])
    else $error("drive active during current fault");
  freq_float_a: assert property (freq_held |-> !status_flags[ST_DRIVE])
    else $error("drive active during frequency fault");
  ratio_float_a: assert property (ratio_held |-> !status_flags[ST_DRIVE])
    else $error("drive active during ratio fault");
  off_float_a: assert property (!amp_mode [*3] |-> !status_flags[ST_DRIVE])
    else $error("drive active while off");
  otp_sticky_a: assert property (status_flags[ST_OTP] && otp_recovery == REC_NONE && fault_clear == 2'h0
    && !$past(fault_clear[0]) and amp_steady |=> status_flags[ST_OTP])
    else $error("temperature flag dropped without clear");
  ocp_sticky_a: assert property (status_flags[ST_OCP] && ocp_recovery == REC_NONE && fault_clear == 2'h0
    && !$past(fault_clear[1]) and amp_steady |=> status_flags[ST_OCP])
    else $error("current flag dropped without clear");
  freq_excl_a: assert property (!(status_flags[ST_UFP] && status_flags[ST_OFP]))
    else $error("under and over frequency together");
  clear_pulse_a: assert property (fault_clear != 2'h0 |=> fault_clear == 2'h0)
    else $error("clear pulse longer than one cycle");
  ws_edge_a: assert property ($changed(ws) |-> !sck)
    else $error("word select moved off falling bit clock");
  sd_edge_a: assert property ($changed(sd) |-> !sck)
    else $error("serial data moved off falling bit clock");
endmodule // alp_link_properties

// ---- alp_pkg.sv ----
package alp_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam real CLK_MHZ = 250.0;
  localparam int AUDIO_W = 16;
  localparam int SUPPLY_W = 13;
  localparam int MV_W = 16;
  localparam int INT_W = 20;
  localparam int MOD_SHIFT = 2;
  localparam int CLIP_HEAD_SHIFT = 3;
  // Full-scale output 5.91 V held in millivolts
  localparam int FS_OUT_MV = 5910;
  localparam int FRAC_SHIFT = 15;

  // Frame-rate watchdog limits
  localparam int UFP_HZ = 96_000;
  localparam int OFP_HZ = 1_031_000;
  localparam int PWM_PER_FS = 32;
  localparam int PER_W = 18;
  localparam logic [PER_W-1:0] UFP_PER_MAX = PER_W'(64'(CLK_HZ) * PWM_PER_FS / UFP_HZ);
  localparam logic [PER_W-1:0] OFP_PER_MIN = PER_W'(64'(CLK_HZ) * PWM_PER_FS / OFP_HZ);

  // Sample-rate select: family in low bits, octave above
  localparam int SRS_W = 4;
  localparam int SRS_FAM_LSB = 0;
  localparam int SRS_OCT_LSB = 2;
  localparam logic [1:0] FAM_8K = 2'h0;
  localparam logic [1:0] FAM_11K = 2'h1;
  localparam int PWM_HZ_8K = 256_000;
  localparam int PWM_HZ_11K = 352_800;
  localparam int PWM_HZ_12K = 384_000;
  localparam int DIV_W = 10;

  function automatic logic [DIV_W-1:0] pwm_div(input logic [1:0] fam);
    return (fam == FAM_8K) ? DIV_W'(CLK_HZ / PWM_HZ_8K) :
           (fam == FAM_11K) ? DIV_W'(CLK_HZ / PWM_HZ_11K) : DIV_W'(CLK_HZ / PWM_HZ_12K);
  endfunction

  // Recovery delays
  localparam real REC_SHORT_US = 4.5;
  localparam real OTP_MID_MS = 100.0;
  localparam real OTP_LONG_S = 1.0;
  localparam real OCP_MID_US = 27.5;
  localparam real OCP_LONG_MS = 10.0;
  localparam int REC_W = 28;
  localparam int REC_SHORT_CYC = int'($ceil(REC_SHORT_US * CLK_MHZ));
  localparam int OTP_MID_CYC_DEF = int'($ceil(OTP_MID_MS * 1000.0 * CLK_MHZ));
  localparam int OTP_LONG_CYC_DEF = int'($ceil(OTP_LONG_S * 1000000.0 * CLK_MHZ));
  localparam int OCP_MID_CYC_DEF = int'($ceil(OCP_MID_US * CLK_MHZ));
  localparam int OCP_LONG_CYC_DEF = int'($ceil(OCP_LONG_MS * 1000.0 * CLK_MHZ));
  typedef enum logic [1:0] {REC_NONE, REC_SHORT, REC_MID, REC_LONG} alp_recovery_t;

  // Limiter gain: 0.5 dB per code, 12 codes per halving
  localparam int GAIN_W = 8;
  localparam logic [GAIN_W-1:0] GAIN_CODE_MAX = 8'hF8;
  localparam logic [GAIN_W-1:0] GAIN_CODE_RST = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_STEPS_PER_6DB = 8'h0C;
  localparam int GAIN_FRAC_W = 16;

  function automatic logic [GAIN_FRAC_W-1:0] gain_frac(input logic [3:0] r);
    case (r)
      4'h0: return 16'h7FFF;
      4'h1: return 16'h78D7;
      4'h2: return 16'h7215;
      4'h3: return 16'h6BB3;
      4'h4: return 16'h65AD;
      4'h5: return 16'h5FFD;
      4'h6: return 16'h5A9E;
      4'h7: return 16'h558C;
      4'h8: return 16'h50C3;
      4'h9: return 16'h4C3F;
      4'hA: return 16'h47FB;
      default: return 16'h43F4;
    endcase
  endfunction

  localparam int BCR_W = 9;
  function automatic logic bitclk_ratio_ok(input logic pcm, input logic [BCR_W-1:0] n);
    if (pcm)
      return n inside {9'h010, 9'h020, 9'h030, 9'h040, 9'h060, 9'h080, 9'h0C0};
    return n inside {9'h020, 9'h040};
  endfunction

  // Status word bits
  localparam int ST_OTP = 0;
  localparam int ST_OCP = 1;
  localparam int ST_UFP = 2;
  localparam int ST_OFP = 3;
  localparam int ST_IBP = 4;
  localparam int ST_DRIVE = 5;
  localparam int ST_W = 6;

  // Controller register map (byte addresses)
  localparam int AVS_ADDR_W = 5;
  localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] REG_GAIN = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] REG_SAMPLE = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] REG_FRAME = 5'h0C;
  localparam logic [AVS_ADDR_W-1:0] REG_CLEAR = 5'h10;
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 5'h14;
  localparam int CTL_AMP = 0;
  localparam int CTL_CLIP = 1;
  localparam int CTL_PCM = 2;
  localparam int CTL_SRS_LSB = 4;
  localparam int CTL_OTP_LSB = 8;
  localparam int CTL_OCP_LSB = 10;
  localparam int CTL_W = 12;
  localparam logic [CTL_W-1:0] CTRL_RST = 12'h000;
  localparam int FRM_BITS_LSB = 0;
  localparam int FRM_HALF_LSB = 16;
  localparam logic [7:0] FRAME_BITS_RST = 8'h40;
  localparam logic [7:0] SCK_HALF_RST = 8'h14;
endpackage

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top
  import alp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AVS_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic over_temp_alarm = 1'b0;
  logic over_current_alarm = 1'b0;
  logic [SUPPLY_W-1:0] power_stage_supply = 13'h0BB8;
  logic speaker_out_pos, speaker_out_pos_oe, speaker_out_neg, speaker_out_neg_oe;
  logic signed [MV_W-1:0] drive_level_mv;
  logic [31:0] rd;
  int errors = 0;
  int checked = 0;
  logic [AVS_ADDR_W-1:0] ra [5] = '{REG_CTRL, REG_GAIN, REG_FRAME, REG_CLEAR, 5'h18};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h00140040, 32'h0, 32'h0};

  always #2 sys_clk = ~sys_clk;

  alp_link_if lnk();
  alp_amp_device #(.OTP_MID_CYC(200), .OTP_LONG_CYC(400), .OCP_MID_CYC(100), .OCP_LONG_CYC(300))
    u_alp_amp_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(lnk), .over_temp_alarm(over_temp_alarm),
    .over_current_alarm(over_current_alarm), .power_stage_supply(power_stage_supply),
    .speaker_out_pos(speaker_out_pos), .speaker_out_pos_oe(speaker_out_pos_oe), .speaker_out_neg(speaker_out_neg),
    .speaker_out_neg_oe(speaker_out_neg_oe), .drive_level_mv(drive_level_mv));
  alp_audio_host u_alp_audio_host (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(lnk));
  alp_link_properties u_alp_link_properties (.sys_clk(sys_clk), .rst_n(rst_n), .sck(lnk.sck), .ws(lnk.ws),
    .sd(lnk.sd), .amp_mode(lnk.amp_mode), .otp_recovery(lnk.otp_recovery), .ocp_recovery(lnk.ocp_recovery),
    .fault_clear(lnk.fault_clear), .status_flags(lnk.status_flags));

  // Entered just after a rising edge; the iff sees waitrequest as sampled at the edge
  task automatic avs_wr(input logic [AVS_ADDR_W-1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge sys_clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic avs_rd(input logic [AVS_ADDR_W-1:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge sys_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic poll(input logic [31:0] exp, input int lim);
    int n = 0;
    avs_rd(REG_STATUS);
    while (rd !== exp && n < lim)
    begin
      avs_rd(REG_STATUS);
      n++;
    end
    `CHK(rd, exp)
  endtask

  task automatic final_report();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK(speaker_out_pos_oe, 1'b0)
    avs_rd(REG_STATUS);
    `CHK(rd, 32'h0)
    avs_wr(5'h18, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++)
    begin
      avs_rd(ra[i]);
      `CHK(rd, rv[i])
    end
    // Full-scale input saturates at a 3000 mV supply
    avs_wr(REG_SAMPLE, 32'h7FFF);
    avs_wr(REG_CTRL, 32'h1C3);
    poll(32'h20, 3000);
    repeat (5120) @(posedge sys_clk);
    `CHK(drive_level_mv, 16'h0BB8)
    `CHK(speaker_out_pos_oe & speaker_out_neg_oe, 1'b1)
    `CHK({speaker_out_pos, speaker_out_neg}, 2'b10)
    avs_wr(REG_CTRL, 32'h1C1);
    repeat (20) @(posedge sys_clk);
    `CHK(drive_level_mv, 16'h0A41)
    avs_wr(REG_CTRL, 32'h1C3);
    avs_wr(REG_GAIN, 32'hF8);
    repeat (20) @(posedge sys_clk);
    `CHK(drive_level_mv, 16'h0000)
    avs_wr(REG_GAIN, 32'h0C);
    repeat (20) @(posedge sys_clk);
    `CHK(drive_level_mv > 16'sd2900 && drive_level_mv < 16'sd3000, 1'b1)
    avs_wr(REG_GAIN, 32'h00);
    over_temp_alarm <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(speaker_out_pos_oe | speaker_out_neg_oe, 1'b0)
    avs_wr(REG_CLEAR, 32'h1);
    poll(32'h01, 0);
    over_temp_alarm <= 1'b0;
    repeat (1000) @(posedge sys_clk);
    poll(32'h01, 0);
    poll(32'h20, 200);
    over_current_alarm <= 1'b1;
    repeat (8) @(posedge sys_clk);
    over_current_alarm <= 1'b0;
    repeat (2000) @(posedge sys_clk);
    poll(32'h02, 0);
    avs_wr(REG_CLEAR, 32'h2);
    poll(32'h20, 3000);
    // Both faults with no recovery: no timer, so a host clear or the off-amp cycle clears them
    avs_wr(REG_CTRL, 32'h0C3);
    over_temp_alarm <= 1'b1;
    over_current_alarm <= 1'b1;
    repeat (8) @(posedge sys_clk);
    over_temp_alarm <= 1'b0;
    over_current_alarm <= 1'b0;
    repeat (1200) @(posedge sys_clk);
    poll(32'h03, 0);
    avs_wr(REG_CTRL, 32'h0C2);
    repeat (20) @(posedge sys_clk);
    `CHK(drive_level_mv, 16'h0000)
    avs_wr(REG_CTRL, 32'h0C3);
    poll(32'h20, 3000);
    avs_wr(REG_CTRL, 32'h103);
    poll(32'h08, 3000);
    avs_wr(REG_CTRL, 32'h1C3);
    poll(32'h20, 3000);
    avs_wr(REG_FRAME, 32'h00140032);
    poll(32'h10, 3000);
    avs_wr(REG_CTRL, 32'h1C7);
    avs_wr(REG_FRAME, 32'h00140030);
    poll(32'h20, 3000);
    avs_wr(REG_CTRL, 32'h1C3);
    avs_wr(REG_FRAME, 32'h00640040);
    poll(32'h04, 12000);
    `CHK(speaker_out_pos_oe, 1'b0)
    avs_wr(REG_FRAME, 32'h00140040);
    poll(32'h20, 12000);
    final_report();
  end
endmodule // tb_top
